// ### include/ovh_ins_params.svh
`ifndef OVH_INS_PARAMS_SVH
`define OVH_INS_PARAMS_SVH

// ----------------------------------------------------------------
// port count
// ----------------------------------------------------------------
`define OVH_NUM_CH          3

// ----------------------------------------------------------------
// register map (byte addresses) and fields
// ----------------------------------------------------------------
`define OVH_REG_CTRL        8'h00
`define OVH_REG_STATUS      8'h04
`define OVH_CTRL_RST        32'h0000_0000
`define OVH_CTRL_STRIDE     4
`define OVH_CTRL_MODE_LSB   0
`define OVH_CTRL_BOTH_BIT   2
`define OVH_STAT_PEND_BIT   8

// ----------------------------------------------------------------
// frame geometry: ds3/e3 in overhead-port clock periods, sts-1 in rows and columns
// ----------------------------------------------------------------
`define OVH_DS3_BITS        13'h1298
`define OVH_DS3_GAP_LAST    7'h54
`define OVH_E3_BITS         13'h0600
`define OVH_E3_OH_BITS      13'h000c
`define OVH_STS_COL_LAST    7'h59
`define OVH_STS_ROW_LAST    4'h8
`define OVH_STS_TOH_COLS    7'h03
`define OVH_STS_POH_COL     7'h03

`endif

// ### include/ovh_ins_pkg.sv
`include "ovh_ins_params.svh"
`default_nettype none

package ovh_ins_pkg;

	typedef enum logic [1:0] {
		MODE_OFF  = 2'h0,
		MODE_DS3  = 2'h1,
		MODE_E3   = 2'h2,
		MODE_STS1 = 2'h3
	} chan_mode_e;

	typedef enum logic [1:0] {
		HS_IDLE = 2'h1,
		HS_WAIT = 2'h2
	} hs_state_e;

	typedef struct packed {
		chan_mode_e mode;
		logic       both;
	} chan_cfg_s;

	typedef struct packed {
		logic [3:0] row;
		logic [6:0] col;
		logic [2:0] bitc;
	} sts_pos_s;

	typedef struct packed {
		logic [12:0] dpos;
		logic [6:0]  dgap;
		sts_pos_s    sp;
		logic        frame;
		logic        enable;
		logic        out_bit;
		logic        acc;
		logic        seen_lvl;
	} chan_st_s;

	typedef struct packed {
		chan_cfg_s [`OVH_NUM_CH-1:0] cfg;
		logic                        req_tgl;
		logic                        ack_s1;
		logic                        ack_s2;
		logic [`OVH_NUM_CH-1:0]      st_s1;
		logic [`OVH_NUM_CH-1:0]      st_s2;
		hs_state_e                   hs;
		logic [31:0]                 prdata;
	} ap_s;

	typedef struct packed {
		logic                        port_clk;
		logic                        req_s1;
		logic                        req_s2;
		logic                        req_seen;
		chan_cfg_s [`OVH_NUM_CH-1:0] cfg;
		chan_st_s [`OVH_NUM_CH-1:0]  ch;
	} lk_s;

endpackage

`default_nettype wire

// ### verification/ovh_ins_monitor.sv
`default_nettype none
module ovh_ins_monitor #(
	parameter int NUM_CH = 3
) (
	// apb
	input wire logic              pclk,
	input wire logic              presetn,
	input wire logic              psel,
	input wire logic              penable,
	input wire logic              pwrite,
	input wire logic [7:0]        paddr,
	input wire logic              pready,
	input wire logic              pslverr,
	// link
	input wire logic              tx_input_clock,
	input wire logic [NUM_CH-1:0] ovh_port_clock_out,
	input wire logic [NUM_CH-1:0] ovh_frame_pulse_out,
	input wire logic [NUM_CH-1:0] ovh_slot_enable_out,
	input wire logic [NUM_CH-1:0] ovh_insert_strobe_in,
	input wire logic              frm_bit_take,
	input wire logic [NUM_CH-1:0] frm_bit_in,
	input wire logic [NUM_CH-1:0] frm_bit_out
);
	timeunit 1ns;
	timeprecision 1ps;
	// ----------------------------------------
	// pulse run lengths, last port
	// ----------------------------------------
	logic [4:0] frun_r;
	logic [4:0] erun_r;
	always_ff @(posedge tx_input_clock or negedge presetn) begin
		if (!presetn) begin
			frun_r <= 5'h00;
			erun_r <= 5'h00;
		end else begin
			frun_r <= ovh_frame_pulse_out[NUM_CH-1] ? frun_r + 5'h01 : 5'h00;
			erun_r <= ovh_slot_enable_out[NUM_CH-1] ? erun_r + 5'h01 : 5'h00;
		end
	end
	property p_clk_fall;
		@(posedge tx_input_clock) disable iff (!presetn) frm_bit_take |=> !ovh_port_clock_out[0];
	endproperty
	a_clk_fall: assert property (p_clk_fall) else $error("port clock high twice");
	property p_clk_same;
		@(posedge tx_input_clock) disable iff (!presetn) ovh_port_clock_out == {NUM_CH{frm_bit_take}};
	endproperty
	a_clk_same: assert property (p_clk_same) else $error("port clocks differ");
	property p_out_tick;
		@(posedge tx_input_clock) disable iff (!presetn) $changed(frm_bit_out) |-> $past(frm_bit_take);
	endproperty
	a_out_tick: assert property (p_out_tick) else $error("bit out off tick");
	property p_keep;
		@(posedge tx_input_clock) disable iff (!presetn) frm_bit_take |=>
			((frm_bit_out ^ $past(frm_bit_in)) & ~$past(ovh_insert_strobe_in)) == '0;
	endproperty
	a_keep: assert property (p_keep) else $error("unstrobed bit replaced");
	property p_frame_len;
		@(posedge tx_input_clock) disable iff (!presetn) frun_r <= 5'h10;
	endproperty
	a_frame_len: assert property (p_frame_len) else $error("frame pulse too long");
	property p_en_len;
		@(posedge tx_input_clock) disable iff (!presetn) erun_r <= 5'h10;
	endproperty
	a_en_len: assert property (p_en_len) else $error("enable too long");
	property p_err_map;
		@(posedge pclk) disable iff (!presetn) psel && penable |->
			pslverr == (paddr != 8'h00 && paddr != 8'h04);
	endproperty
	a_err_map: assert property (p_err_map) else $error("error flag wrong");
	property p_rd_ready;
		@(posedge pclk) disable iff (!presetn) psel && penable && !pwrite |-> pready;
	endproperty
	a_rd_ready: assert property (p_rd_ready) else $error("read stalled");
	c_ins: cover property (@(posedge tx_input_clock) frm_bit_take && ovh_insert_strobe_in[0]);
	c_wait: cover property (@(posedge pclk) psel && penable && !pready);
	c_frame: cover property (@(posedge tx_input_clock) $rose(ovh_frame_pulse_out[NUM_CH-1]));
endmodule
bind tx_overhead_serial_insert_port ovh_ins_monitor #(.NUM_CH(NUM_CH)) i_ovh_ins_monitor (
	.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pready, .pslverr, .tx_input_clock,
	.ovh_port_clock_out, .ovh_frame_pulse_out, .ovh_slot_enable_out, .ovh_insert_strobe_in,
	.frm_bit_take, .frm_bit_in, .frm_bit_out
);
`default_nettype wire

// ### verification/ovh_term_model.sv
`default_nettype none
module ovh_term_model (
	// link
	input  wire logic       tx_input_clock,
	input  wire logic       presetn,
	input  wire logic [2:0] ovh_slot_enable_out,
	// scenario
	input  wire logic [2:0] ins_on,
	input  wire logic [2:0] hold,
	// insertion
	output logic      [2:0] ovh_insert_strobe_in,
	output logic      [2:0] ovh_serial_data_in
);
	timeunit 1ns;
	timeprecision 1ps;
	// every channel here runs as a mapper, so no reference clock is driven
	logic [2:0] want;
	assign want = ins_on & (hold | ovh_slot_enable_out);
	// idle data toggles, so a design reading it without strobe shows up
	always @(negedge tx_input_clock or negedge presetn) begin
		if (!presetn) begin
			ovh_insert_strobe_in <= 3'h0;
			ovh_serial_data_in <= 3'h0;
		end else begin
			ovh_insert_strobe_in <= want;
			ovh_serial_data_in <= want | ~ovh_serial_data_in;
		end
	end
endmodule
`default_nettype wire

// ### verification/tb_top.sv
`default_nettype none
module tb_top;
	timeunit 1ns;
	timeprecision 1ps;
	logic            pclk = 1'b0;
	logic            tx_input_clock = 1'b0;
	logic            presetn = 1'b0;
	logic            psel = 1'b0;
	logic            penable = 1'b0;
	logic            pwrite = 1'b0;
	logic [7:0]      paddr = 8'h00;
	logic [31:0]     pwdata = 32'h0000_0000;
	logic [31:0]     prdata;
	logic            pready, pslverr, frm_bit_take;
	logic [2:0]      ovh_port_clock_out, ovh_frame_pulse_out, ovh_slot_enable_out;
	logic [2:0]      ovh_serial_data_in, ovh_insert_strobe_in, frm_bit_out;
	logic [2:0]      frm_bit_in = 3'h0;
	logic [2:0]      ins_on = 3'h0;
	logic [2:0]      hold = 3'h0;
	logic [2:0][1:0] md = 6'h00;
	logic            meas = 1'b0;
	int              nt, num_errors, comparisons;
	int              ones [3], frs [3], ens [3];
	tx_overhead_serial_insert_port i_tx_overhead_serial_insert_port (
		.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
		.pslverr, .tx_input_clock, .ovh_port_clock_out, .ovh_frame_pulse_out,
		.ovh_slot_enable_out, .ovh_serial_data_in, .ovh_insert_strobe_in,
		.frm_bit_take, .frm_bit_in, .frm_bit_out
	);
	ovh_term_model i_ovh_term_model (
		.tx_input_clock, .presetn, .ovh_slot_enable_out, .ins_on, .hold,
		.ovh_insert_strobe_in, .ovh_serial_data_in
	);
	always #20 pclk = ~pclk;
	always begin
		#1.3;
		forever #3 tx_input_clock = ~tx_input_clock;
	end
	function automatic int flen(input logic [1:0] m);
		case (m)
			ovh_ins_pkg::MODE_DS3: return 4760;
			ovh_ins_pkg::MODE_E3: return 1536;
			default: return 9 * 90 * 8;
		endcase
	endfunction
	function automatic int nacc(input logic [1:0] m, input logic b);
		case (m)
			ovh_ins_pkg::MODE_DS3: return 4760 / 85;
			ovh_ins_pkg::MODE_E3: return 12;
			ovh_ins_pkg::MODE_STS1: return b ? 9 * 4 * 8 : 9 * 8;
			default: return 0;
		endcase
	endfunction
	// port periods per frame with the frame pulse high
	function automatic int nfr(input logic [1:0] m, input logic b);
		case (m)
			ovh_ins_pkg::MODE_DS3: return 1;
			ovh_ins_pkg::MODE_E3: return 1;
			ovh_ins_pkg::MODE_STS1: return b ? 16 : 8;
			default: return 0;
		endcase
	endfunction
	// counted at the falling link edge, clear of the tick update
	always @(negedge tx_input_clock) begin
		if (!meas) begin
			nt = 0;
			ones = '{0, 0, 0};
			frs = '{0, 0, 0};
			ens = '{0, 0, 0};
		end else if (frm_bit_take === 1'b1) begin
			for (int c = 0; c < 3; c++) begin
				if (nt < flen(md[c])) begin
					ones[c] += int'(frm_bit_out[c] === 1'b1);
					frs[c] += int'(ovh_frame_pulse_out[c] === 1'b1);
					ens[c] += int'(ovh_slot_enable_out[c] === 1'b1);
				end
			end
			nt++;
		end
	end
	task automatic test_done;
		if (num_errors == 0 && comparisons > 0) begin
			$display("*** PASS ***");
		end else begin
			$display("*** FAIL ***");
		end
		$finish;
	endtask
	task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		comparisons++;
		if (g !== e) begin
			num_errors++;
			$display("wrong value %s expected %h seen %h", nm, e, g);
		end
	endtask
	task automatic hang(input int n);
		if (n > 3000) begin
			num_errors++;
			test_done();
		end
	endtask
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
			output logic [31:0] q, output logic e);
		int n;
		n = 0;
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		// look mid-cycle, where pready and the read data have settled
		@(negedge pclk);
		while (pready !== 1'b1) begin
			n++;
			hang(n);
			@(negedge pclk);
		end
		q = prdata;
		e = pslverr;
		// the rising edge after a high look is the one that takes the transfer
		@(posedge pclk);
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge pclk);
	endtask
	task automatic round(input logic [2:0][1:0] m, input logic [2:0] b, input logic [2:0] o);
		logic [31:0] q, w, s;
		logic e;
		int n;
		w = 32'h0000_0000;
		s = 32'h0000_0000;
		for (int c = 0; c < 3; c++) begin
			w[4*c+:2] = m[c];
			w[4*c+2] = b[c];
			s[c] = o[c] && m[c] != ovh_ins_pkg::MODE_OFF;
			hold[c] <= m[c] == ovh_ins_pkg::MODE_STS1;
		end
		md = m;
		ins_on <= o;
		// unstrobed channels carry ones, so a lost framer bit shows
		frm_bit_in <= ~o;
		apb(1'b1, 8'h00, w, q, e);
		apb(1'b0, 8'h00, 32'h0000_0000, q, e);
		chk("ctrl", w, q);
		repeat (40) @(posedge pclk);
		meas <= 1'b1;
		n = 0;
		while (nt < 9 * 90 * 8) begin
			n++;
			hang(n);
			@(posedge pclk);
		end
		for (int c = 0; c < 3; c++) begin
			chk("inserted", o[c] ? nacc(m[c], b[c]) : flen(m[c]), ones[c]);
			chk("frame ticks", nfr(m[c], b[c]), frs[c]);
			// one enable period per overhead bit; sts-1 enables path bytes only
			chk("enable ticks", nacc(m[c], 1'b0), ens[c]);
		end
		meas <= 1'b0;
		repeat (2000) @(posedge pclk);
		apb(1'b0, 8'h04, 32'h0000_0000, q, e);
		chk("status", s, q);
	endtask
	initial begin
		logic [31:0] q;
		logic e;
		num_errors = 0;
		comparisons = 0;
		void'($urandom(42));
		repeat (2) @(posedge pclk);
		presetn <= 1'b1;
		@(posedge pclk);
		apb(1'b0, 8'h00, 32'h0000_0000, q, e);
		chk("ctrl reset", 32'h0000_0000, q);
		apb(1'b1, 8'h04, 32'hffff_ffff, q, e);
		apb(1'b0, 8'h04, 32'h0000_0000, q, e);
		chk("status", 32'h0000_0000, q);
		apb(1'b0, 8'h08, 32'h0000_0000, q, e);
		chk("unmapped", 32'h0000_0001, {31'h0000_0000, e});
		apb(1'b1, 8'h00, 32'h0000_0111, q, e);
		apb(1'b1, 8'h00, 32'h0000_0000, q, e);
		round({ovh_ins_pkg::MODE_STS1, ovh_ins_pkg::MODE_E3, ovh_ins_pkg::MODE_DS3}, 3'h0, 3'h7);
		round({ovh_ins_pkg::MODE_DS3, ovh_ins_pkg::MODE_STS1, ovh_ins_pkg::MODE_E3}, 3'h2, 3'h6);
		for (int r = 0; r < 3; r++) begin
			round(6'($urandom), 3'($urandom), 3'($urandom));
		end
		test_done();
	end
endmodule
`default_nettype wire

// ### verilog/tx_overhead_serial_insert_port.sv
`include "ovh_ins_params.svh"
`default_nettype none
// Function
// - ds3/e3 data latched at port clock fall
// - accepted bits replace ds3/e3 overhead positions
// - strobe low means input data ignored
// - enable high one input clock before sampling
// - bit latched at next input clock rise
// - sts-1 outputs change at port clock fall
// - sts-1 strobe and data sampled at fall
// - sts-1 enable high only for path bytes
// - frame pulse eight periods, one early
// - enable rises one period before each byte
// - both mode: frame pulse twice per frame
// - frame with enable low means transport byte
// - three independent ports, one per channel

module tx_overhead_serial_insert_port #(
	parameter int NUM_CH = `OVH_NUM_CH
) (
	// apb slave, pclk domain
	input  wire logic              pclk,
	input  wire logic              presetn,
	input  wire logic              psel,
	input  wire logic              penable,
	input  wire logic              pwrite,
	input  wire logic [7:0]        paddr,
	input  wire logic [31:0]       pwdata,
	output logic      [31:0]       prdata,
	output logic                   pready,
	output logic                   pslverr,
	// link clock
	input  wire logic              tx_input_clock,
	// overhead insertion ports
	output logic      [NUM_CH-1:0] ovh_port_clock_out,
	output logic      [NUM_CH-1:0] ovh_frame_pulse_out,
	output logic      [NUM_CH-1:0] ovh_slot_enable_out,
	input  wire logic [NUM_CH-1:0] ovh_serial_data_in,
	input  wire logic [NUM_CH-1:0] ovh_insert_strobe_in,
	// framer side bit streams
	output logic                   frm_bit_take,
	input  wire logic [NUM_CH-1:0] frm_bit_in,
	output logic      [NUM_CH-1:0] frm_bit_out
);

	// ----------------------------------------------------------------
	// elaboration check
	// ----------------------------------------------------------------
	if (NUM_CH != `OVH_NUM_CH) begin
		$error("NUM_CH must equal the packaged channel count");
	end

	// ----------------------------------------------------------------
	// position helpers
	// ----------------------------------------------------------------
	function automatic logic [12:0] ds_len(input ovh_ins_pkg::chan_mode_e m);
		return (m == ovh_ins_pkg::MODE_E3) ? `OVH_E3_BITS : `OVH_DS3_BITS;
	endfunction

	function automatic ovh_ins_pkg::sts_pos_s sts_adv(input ovh_ins_pkg::sts_pos_s p);
		ovh_ins_pkg::sts_pos_s n;
		n = p;
		n.bitc = p.bitc + 3'h1;
		if (p.bitc == 3'h7) begin
			if (p.col == `OVH_STS_COL_LAST) begin
				n.col = 7'h00;
				n.row = (p.row == `OVH_STS_ROW_LAST) ? 4'h0 : p.row + 4'h1;
			end else begin
				n.col = p.col + 7'h01;
			end
		end
		return n;
	endfunction

	function automatic logic sts_last(input ovh_ins_pkg::sts_pos_s p);
		return p.row == `OVH_STS_ROW_LAST && p.col == `OVH_STS_COL_LAST && p.bitc == 3'h7;
	endfunction

	function automatic logic is_poh(input ovh_ins_pkg::sts_pos_s p);
		return p.col == `OVH_STS_POH_COL;
	endfunction

	function automatic logic is_ovh(input ovh_ins_pkg::chan_cfg_s c,
	                                input ovh_ins_pkg::chan_st_s s);
		case (c.mode)
			ovh_ins_pkg::MODE_DS3:  return s.dgap == 7'h00;
			ovh_ins_pkg::MODE_E3:   return s.dpos < `OVH_E3_OH_BITS;
			ovh_ins_pkg::MODE_STS1: return is_poh(s.sp) || (c.both && s.sp.col < `OVH_STS_TOH_COLS);
			default:                return 1'b0;
		endcase
	endfunction

	// ----------------------------------------------------------------
	// link reset: asserted at once, released on the link clock
	// ----------------------------------------------------------------
	logic lrst_s1_r;
	logic lrst_n_r;

	always_ff @(posedge tx_input_clock or negedge presetn) begin
		if (!presetn) begin
			lrst_s1_r <= 1'b0;
			lrst_n_r  <= 1'b0;
		end else begin
			lrst_s1_r <= 1'b1;
			lrst_n_r  <= lrst_s1_r;
		end
	end

	// ----------------------------------------------------------------
	// apb domain
	// ----------------------------------------------------------------
	ovh_ins_pkg::ap_s ap_r;
	ovh_ins_pkg::ap_s ap_nxt;
	ovh_ins_pkg::lk_s lk_r;
	ovh_ins_pkg::lk_s lk_nxt;
	logic             ctrl_hit;
	logic             stat_hit;
	logic             access;

	assign ctrl_hit = paddr == `OVH_REG_CTRL;
	assign stat_hit = paddr == `OVH_REG_STATUS;
	assign access   = psel && penable;
	// a second control write waits until the link has taken the first
	assign pready   = !(ctrl_hit && pwrite && ap_r.hs == ovh_ins_pkg::HS_WAIT);
	assign pslverr  = access && !ctrl_hit && !stat_hit;
	assign prdata   = ap_r.prdata;

	always_comb begin
		ap_nxt        = ap_r;
		ap_nxt.ack_s1 = lk_r.req_seen;
		ap_nxt.ack_s2 = ap_r.ack_s1;
		for (int i = 0; i < NUM_CH; i++) begin
			ap_nxt.st_s1[i] = lk_r.ch[i].seen_lvl;
		end
		ap_nxt.st_s2 = ap_r.st_s1;
		case (ap_r.hs)
			ovh_ins_pkg::HS_IDLE: begin
				if (access && pwrite && ctrl_hit) begin
					for (int i = 0; i < NUM_CH; i++) begin
						ap_nxt.cfg[i].mode = ovh_ins_pkg::chan_mode_e'(
							pwdata[i*`OVH_CTRL_STRIDE+`OVH_CTRL_MODE_LSB +: 2]);
						ap_nxt.cfg[i].both = pwdata[i*`OVH_CTRL_STRIDE+`OVH_CTRL_BOTH_BIT];
					end
					ap_nxt.req_tgl = !ap_r.req_tgl;
					ap_nxt.hs      = ovh_ins_pkg::HS_WAIT;
				end
			end
			ovh_ins_pkg::HS_WAIT: begin
				if (ap_r.ack_s2 == ap_r.req_tgl) begin
					ap_nxt.hs = ovh_ins_pkg::HS_IDLE;
				end
			end
			default: begin
				ap_nxt.hs = ovh_ins_pkg::HS_IDLE;
			end
		endcase
		// read data is registered in the setup cycle, valid through access
		if (psel && !penable) begin
			ap_nxt.prdata = 32'h0000_0000;
			if (ctrl_hit) begin
				for (int i = 0; i < NUM_CH; i++) begin
					ap_nxt.prdata[i*`OVH_CTRL_STRIDE+`OVH_CTRL_MODE_LSB +: 2] = ap_r.cfg[i].mode;
					ap_nxt.prdata[i*`OVH_CTRL_STRIDE+`OVH_CTRL_BOTH_BIT]     = ap_r.cfg[i].both;
				end
			end else if (stat_hit) begin
				ap_nxt.prdata[NUM_CH-1:0]         = ap_r.st_s2;
				ap_nxt.prdata[`OVH_STAT_PEND_BIT] = ap_r.hs == ovh_ins_pkg::HS_WAIT;
			end
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ap_r    <= '0;
			ap_r.hs <= ovh_ins_pkg::HS_IDLE;
		end else begin
			ap_r <= ap_nxt;
		end
	end

	// ----------------------------------------------------------------
	// link domain: port clock is the link clock divided by two; a tick is
	// the link edge at which the port clock falls
	// ----------------------------------------------------------------
	logic                      tick;
	logic                      load;
	logic                      ovh;
	logic                      ins;
	logic                      wrap;
	ovh_ins_pkg::chan_cfg_s    cc;
	ovh_ins_pkg::chan_st_s     cs;
	ovh_ins_pkg::chan_st_s     ns;
	ovh_ins_pkg::sts_pos_s     look;

	assign tick = lk_r.port_clk;

	always_comb begin
		lk_nxt          = lk_r;
		cc              = lk_r.cfg[0];
		cs              = lk_r.ch[0];
		ns              = lk_r.ch[0];
		look            = lk_r.ch[0].sp;
		ovh             = 1'b0;
		ins             = 1'b0;
		wrap            = 1'b0;
		lk_nxt.port_clk = !lk_r.port_clk;
		lk_nxt.req_s1   = ap_r.req_tgl;
		lk_nxt.req_s2   = lk_r.req_s1;
		// apb side holds cfg stable until this toggle is echoed back
		load            = lk_r.req_s2 != lk_r.req_seen;
		if (load) begin
			lk_nxt.req_seen = lk_r.req_s2;
			lk_nxt.cfg      = ap_r.cfg;
		end
		for (int i = 0; i < NUM_CH; i++) begin
			cc   = lk_r.cfg[i];
			cs   = lk_r.ch[i];
			ns   = cs;
			look = cs.sp;
			ovh  = is_ovh(cc, cs);
			ins  = ovh && ovh_insert_strobe_in[i];
			wrap = 1'b0;
			if (load || cc.mode == ovh_ins_pkg::MODE_OFF) begin
				ns         = '0;
				ns.out_bit = tick ? frm_bit_in[i] : cs.out_bit;
			end else if (!tick) begin
				if (cc.mode != ovh_ins_pkg::MODE_STS1) begin
					ns.enable = ovh;
				end
			end else begin
				// sample point for both mode families
				ns.out_bit = ins ? ovh_serial_data_in[i] : frm_bit_in[i];
				if (cc.mode != ovh_ins_pkg::MODE_STS1) begin
					wrap = cs.dpos == ds_len(cc.mode) - 13'h0001;
					if (wrap) begin
						ns.dpos = 13'h0000;
						ns.dgap = 7'h00;
					end else begin
						ns.dpos = cs.dpos + 13'h0001;
						ns.dgap = (cs.dgap == `OVH_DS3_GAP_LAST) ? 7'h00 : cs.dgap + 7'h01;
					end
					ns.enable = 1'b0;
					ns.frame  = ns.dpos == 13'h0000;
				end else begin
					wrap = sts_last(cs.sp);
					ns.sp = sts_adv(cs.sp);
					// outputs lead the sampled position by one port clock
					look      = sts_adv(ns.sp);
					ns.enable = is_poh(look);
					ns.frame  = look.row == 4'h0 && (look.col == `OVH_STS_POH_COL
					            || (cc.both && look.col == 7'h00));
				end
				// an insertion on the last bit still counts for that frame
				ns.acc = wrap ? 1'b0 : (cs.acc || ins);
				if (wrap) begin
					ns.seen_lvl = cs.acc || ins;
				end
			end
			lk_nxt.ch[i] = ns;
		end
	end

	always_ff @(posedge tx_input_clock or negedge lrst_n_r) begin
		if (!lrst_n_r) begin
			lk_r <= '0;
		end else begin
			lk_r <= lk_nxt;
		end
	end

	// ----------------------------------------------------------------
	// outputs
	// ----------------------------------------------------------------
	assign frm_bit_take = tick;

	for (genvar g = 0; g < NUM_CH; g++) begin : g_out
		assign ovh_port_clock_out[g]  = lk_r.port_clk;
		assign ovh_frame_pulse_out[g] = lk_r.ch[g].frame;
		assign ovh_slot_enable_out[g] = lk_r.ch[g].enable;
		assign frm_bit_out[g]         = lk_r.ch[g].out_bit;
	end

endmodule

`default_nettype wire
